//--- design/daq_io_regs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte-wide host I/O, offsets relative to a decoded base address
// Notes:   definitions only
`ifndef DAQ_IO_REGS_SVH
`define DAQ_IO_REGS_SVH

`define OFS_ADC_LOW          4'h0
`define OFS_ADC_HIGH         4'h1
`define OFS_SCAN             4'h2
`define OFS_DIO              4'h3
`define OFS_DAC_A_LOW        4'h4
`define OFS_DAC_A_HIGH       4'h5
`define OFS_DAC_B_LOW        4'h6
`define OFS_DAC_B_HIGH       4'h7
`define OFS_STATUS           4'h8

`define SCAN_RESET           8'h00
`define DOUT_RESET           4'h0
`define DAC_RESET            12'h000

`define ST_BUSY_BIT          7
`define ST_POL_BIT           6
`define ST_CFG_BIT           5
`define ST_IRQ_BIT           4

`define CLK_PERIOD_NS        20
`define MUX_ADV_NS           400
// longest time: round down, at least one cycle
`define MUX_ADV_CYC          ((`MUX_ADV_NS / `CLK_PERIOD_NS) < 1 ? 1 : \
                              (`MUX_ADV_NS / `CLK_PERIOD_NS))

`endif

//--- design/daq_io_pkg.sv
// Purpose: shared types of the register front end
// Assumes: included constants header holds all numbers
// Notes:   none
`default_nettype none
package daq_io_pkg;
    typedef enum logic [1:0] {
        conv_idle,
        conv_run
    } conv_state_t;

    typedef logic [3:0] chan_t;
    typedef logic [11:0] code_t;
endpackage
`default_nettype wire

//--- design/dac_pair_if.sv
// Purpose: carries one double-buffered converter channel write port
// Assumes: single clock domain
// Notes:   written by the decoder, read by the channel buffer
`timescale 1ns/10ps
`default_nettype none
interface dac_pair_if;
    logic       low_we;
    logic       high_we;
    logic [7:0] wdata;
    logic [11:0] code;
    modport decoder (output low_we, output high_we, output wdata,
                     input code);
    modport channel (input low_we, input high_we, input wdata,
                     output code);
endinterface
`default_nettype wire

//--- design/dac_double_buffer.sv
// Purpose: one double-buffered 12-bit converter code register
// Assumes: host writes low byte, then high byte
// Notes:   code is straight binary, 0 lowest output, 4095 highest
`timescale 1ns/10ps
`default_nettype none
`include "daq_io_regs.svh"
module dac_double_buffer
    import daq_io_pkg::*;
(
    input  wire logic    ref_clk,
    input  wire logic    rst_b,
    dac_pair_if.channel  bus
);
    logic [3:0] low_hold_r;
    code_t      code_r;

    // low nibble waits in a holding latch so the output moves once
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            low_hold_r <= 4'h0;
            code_r     <= `DAC_RESET;
        end else begin
            if (bus.low_we)
                low_hold_r <= bus.wdata[7:4];
            if (bus.high_we)
                code_r <= {bus.wdata, low_hold_r};
        end
    end

    assign bus.code = code_r;

    // output changes only in the cycle after a high byte write
    stable_code_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !$past(bus.high_we) |-> $stable(code_r))
        else $error("code moved without high byte write");
    code_compose_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        bus.high_we |=> code_r[11:4] == $past(bus.wdata))
        else $error("high byte not loaded");
endmodule
`default_nettype wire

//--- design/daq_board_io_register_front.sv
// Purpose: host register front end of a data acquisition board
// Assumes: byte I/O strobes are synchronous to ref_clk; base decode outside
// Notes:   converter is an external engine with start, done and data
`timescale 1ns/10ps
`default_nettype none
`include "daq_io_regs.svh"

// How it works
// - writing offset 0 starts a conversion; written data ignored.
// - low byte gives channel tag and low result bits; high byte upper bits.
// - result and tag stay latched until next conversion finishes.
// - about 400 ns after start the channel counter advances.
// - after last channel converts, counter reloads first channel.
// - any scan register write reloads counter with first channel.
// - output port write latches bits 3:0; resets to zero.
// - input and output share offset; reads return live input lines.
// - digital read gives inputs low nibble, fixed board id high.
// - input 0 is pacer clock and timer hold gate; input 2 gate zero.
// - each converter code is write only and double buffered.
// - first channel low byte bits 7:4 are low code bits.
// - second channel uses same layout at next two offsets.
// - converter codes are straight binary zero to 4095.
// - status shows busy, polarity, config, irq pending, mux channel.
// - a status write clears pending interrupt and request, unless a conversion ends in the same cycle.
// - conversion done sets pending flag regardless of enable.
// - config flag one for 16 single ended, zero for 8 differential.
// - polarity flag one for unipolar, zero for bipolar.
// - busy reads one during conversion; channel updates after rise.
// - enabled and no dma: request raised at every conversion end.
module daq_board_io_register_front
    import daq_io_pkg::*;
#(
    parameter logic [3:0] BOARD_ID    = 4'h5, // value is arbitrary
    parameter int         MUX_ADV_CYC = `MUX_ADV_CYC
)(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  host_addr,
    input  wire logic        host_rd,
    input  wire logic        host_wr,
    input  wire logic [7:0]  host_wdata,
    output logic [7:0]       host_rdata,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    output logic [3:0]       mux_channel,
    input  wire logic        irq_gate_bit,
    input  wire logic        dma_transfer_bit,
    output logic             irq_request,
    input  wire logic [3:0]  digital_in_lines,
    output logic [3:0]       digital_out_lines,
    output logic             external_pacer_clock,
    output logic             timer_hold_gate,
    output logic             timer_zero_gate,
    input  wire logic        input_config_switch,
    input  wire logic        range_polarity_switch,
    output logic [11:0]      dac_a_code,
    output logic [11:0]      dac_b_code
);
    // pin synchronisers
    logic [3:0] din_meta_r;
    logic [3:0] din_sync_r;
    logic [1:0] sw_meta_r;
    logic [1:0] sw_sync_r;

    conv_state_t state_r;
    conv_state_t state_nxt;
    logic [8:0]  adv_cnt_r;
    logic        adv_pend_r;
    chan_t       chan_r;
    chan_t       conv_chan_r;
    chan_t       tag_r;
    code_t       result_r;
    logic [7:0]  scan_r;
    logic [3:0]  dout_r;
    logic        irq_pend_r;
    logic [7:0]  rdata_r;

    dac_pair_if dac_a_bus ();
    dac_pair_if dac_b_bus ();

    // decode helper used for every strobe
    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        return a == o;
    endfunction

    logic       wr_start;
    logic       wr_scan;
    logic       wr_dout;
    logic       wr_status;
    logic       adv_fire;
    logic       at_last;
    chan_t      first_ch;
    chan_t      last_ch;
    logic [7:0] status_byte;
    logic [7:0] rdata_nxt;

    // write strobes by offset alone
    assign wr_start  = host_wr && hit(host_addr, `OFS_ADC_LOW);
    assign wr_scan   = host_wr && hit(host_addr, `OFS_SCAN);
    assign wr_dout   = host_wr && hit(host_addr, `OFS_DIO);
    assign wr_status = host_wr && hit(host_addr, `OFS_STATUS);
    assign dac_a_bus.low_we  = host_wr && hit(host_addr, `OFS_DAC_A_LOW);
    assign dac_a_bus.high_we = host_wr && hit(host_addr, `OFS_DAC_A_HIGH);
    assign dac_b_bus.low_we  = host_wr && hit(host_addr, `OFS_DAC_B_LOW);
    assign dac_b_bus.high_we = host_wr && hit(host_addr, `OFS_DAC_B_HIGH);
    assign dac_a_bus.wdata   = host_wdata;
    assign dac_b_bus.wdata   = host_wdata;

    assign first_ch = scan_r[3:0];
    assign last_ch  = scan_r[7:4];
    // the tag of the channel being converted decides the wrap
    assign at_last  = (conv_chan_r == last_ch);
    assign adv_fire = adv_pend_r && (adv_cnt_r == 9'(MUX_ADV_CYC - 1));

    dac_double_buffer dac_a_u (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .bus     (dac_a_bus.channel)
    );
    dac_double_buffer dac_b_u (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .bus     (dac_b_bus.channel)
    );

    // two flops on the digital input lines and both switches before any logic reads them
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            din_meta_r <= 4'h0;
            din_sync_r <= 4'h0;
            sw_meta_r  <= 2'b00;
            sw_sync_r  <= 2'b00;
        end else begin
            din_meta_r <= digital_in_lines;
            din_sync_r <= din_meta_r;
            sw_meta_r  <= {range_polarity_switch, input_config_switch};
            sw_sync_r  <= sw_meta_r;
        end
    end

    // converter sequencing; a start while busy is ignored
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            conv_idle: if (wr_start) state_nxt = conv_run;
            conv_run:  if (conv_done) state_nxt = conv_idle;
            default:   state_nxt = conv_idle;
        endcase
    end

    assign conv_start = wr_start && (state_r == conv_idle);

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            state_r <= conv_idle;
        else
            state_r <= state_nxt;
    end

    // delay from start to mux advance, counted in ref_clk cycles
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            adv_pend_r <= 1'b0;
            adv_cnt_r  <= 9'h000;
        end else if (conv_start) begin
            adv_pend_r <= 1'b1;
            adv_cnt_r  <= 9'h000;
        end else if (adv_fire) begin
            adv_pend_r <= 1'b0;
        end else if (adv_pend_r) begin
            adv_cnt_r  <= adv_cnt_r + 9'h001;
        end
    end

    // channel counter; a scan write wins since it reinitialises
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            chan_r      <= 4'h0;
            conv_chan_r <= 4'h0;
        end else begin
            if (conv_start)
                conv_chan_r <= chan_r;
            if (wr_scan)
                chan_r <= host_wdata[3:0];
            else if (adv_fire && at_last)
                chan_r <= first_ch;
            else if (adv_fire)
                chan_r <= chan_r + 4'h1;
        end
    end

    // scan limits and output latch
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            scan_r <= `SCAN_RESET;
            dout_r <= `DOUT_RESET;
        end else begin
            if (wr_scan)
                scan_r <= host_wdata;
            if (wr_dout)
                dout_r <= host_wdata[3:0];
        end
    end

    // result latch holds until the next completion
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            result_r <= 12'h000;
            tag_r    <= 4'h0;
        end else if (state_r == conv_run && conv_done) begin
            result_r <= conv_data;
            tag_r    <= conv_chan_r;
        end
    end

    // pending flag: completion wins over a same-cycle clear
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            irq_pend_r <= 1'b0;
        else if (state_r == conv_run && conv_done)
            irq_pend_r <= 1'b1;
        else if (wr_status)
            irq_pend_r <= 1'b0;
    end

    // request only leaves the board when enabled and not in dma mode
    assign irq_request = irq_pend_r && irq_gate_bit && !dma_transfer_bit;

    assign status_byte = {(state_r == conv_run),
                          sw_sync_r[1],
                          sw_sync_r[0],
                          irq_pend_r,
                          chan_r};

    // read mux; write only and unmapped offsets read as zero
    always_comb begin
        case (host_addr)
            `OFS_ADC_LOW:  rdata_nxt = {result_r[3:0], tag_r};
            `OFS_ADC_HIGH: rdata_nxt = result_r[11:4];
            `OFS_SCAN:     rdata_nxt = scan_r;
            `OFS_DIO:      rdata_nxt = {BOARD_ID, din_sync_r};
            `OFS_STATUS:   rdata_nxt = status_byte;
            default:       rdata_nxt = 8'h00;
        endcase
    end

    // registered read data, valid the cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            rdata_r <= 8'h00;
        else if (host_rd)
            rdata_r <= rdata_nxt;
    end

    assign host_rdata           = rdata_r;
    assign mux_channel          = chan_r;
    assign digital_out_lines    = dout_r;
    assign external_pacer_clock = din_sync_r[0];
    assign timer_hold_gate      = din_sync_r[0];
    assign timer_zero_gate      = din_sync_r[2];
    assign dac_a_code           = dac_a_bus.code;
    assign dac_b_code           = dac_b_bus.code;

    // converter handshake and channel sequencing checks
    start_busy_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        conv_start |=> state_r == conv_run)
        else $error("start did not raise busy");
    result_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !(state_r == conv_run && conv_done) |=> $stable(result_r))
        else $error("result changed without completion");
    result_load_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        state_r == conv_run && conv_done |=>
            result_r == $past(conv_data) && tag_r == $past(conv_chan_r))
        else $error("result or tag not latched");
    tag_capture_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        conv_start |=> conv_chan_r == $past(chan_r))
        else $error("tag not taken at start");
    scan_reload_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wr_scan |=> chan_r == $past(host_wdata[3:0]))
        else $error("scan write did not reload counter");
    advance_time_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        conv_start && !wr_scan |-> ##[1:30] adv_fire)
        else $error("channel advance late");
    chan_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !wr_scan && !adv_fire |=> $stable(chan_r))
        else $error("channel moved without cause");
    wrap_first_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        adv_fire && at_last && !wr_scan |=> chan_r == $past(first_ch))
        else $error("no wrap to first channel");

    // latches and the pending flag
    scan_store_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wr_scan |=> scan_r == $past(host_wdata))
        else $error("scan limits not stored");
    dout_latch_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wr_dout |=> digital_out_lines == $past(host_wdata[3:0]))
        else $error("output latch wrong");
    dout_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !wr_dout |=> $stable(dout_r))
        else $error("output latch moved without write");
    irq_set_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        state_r == conv_run && conv_done |=> irq_pend_r)
        else $error("pending not set");
    irq_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        irq_pend_r && !wr_status |=> irq_pend_r)
        else $error("pending lost without clear");
    irq_clear_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wr_status && !(state_r == conv_run && conv_done) |=> !irq_request)
        else $error("request not withdrawn");

    // read path: a byte read returns what stood at the read edge, so a
    // completion in the same cycle is seen only by the next read
    adc_low_read_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        host_rd && host_addr == `OFS_ADC_LOW |=>
            host_rdata == {$past(result_r[3:0]), $past(tag_r)})
        else $error("result low byte wrong");
    adc_high_read_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        host_rd && host_addr == `OFS_ADC_HIGH |=>
            host_rdata == $past(result_r[11:4]))
        else $error("result high byte wrong");
    dio_read_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        host_rd && host_addr == `OFS_DIO |=> host_rdata[7:4] == BOARD_ID)
        else $error("board id wrong");
    dio_input_read_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        host_rd && host_addr == `OFS_DIO |=>
            host_rdata[3:0] == $past(din_sync_r))
        else $error("input lines not returned");
    status_read_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        host_rd && host_addr == `OFS_STATUS |=>
            host_rdata == $past(status_byte))
        else $error("status byte wrong");
    wo_read_zero_a: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        host_rd && host_addr >= `OFS_DAC_A_LOW &&
            host_addr <= `OFS_DAC_B_HIGH |=> host_rdata == 8'h00)
        else $error("write only code register readable");
endmodule
`default_nettype wire

//--- verif/conv_engine_model.sv
// Purpose: behavioural converter on the far side of the front end
// Assumes: conv_start is a one-cycle pulse sampled on ref_clk
// Notes:   result pattern is built from the channel seen at start
`timescale 1ns/10ps
`default_nettype none
module conv_engine_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        conv_start,
    input  wire logic [3:0]  mux_channel,
    input  wire logic [7:0]  lat_cycles,
    output logic             conv_done,
    output logic [11:0]      conv_data
);
    logic [7:0]  left_r;
    logic [11:0] value_r;

    // count down from start; a start while converting is not taken
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            left_r  <= 8'h00;
            value_r <= 12'h000;
        end else if (conv_start && left_r == 8'h00) begin
            left_r  <= lat_cycles;
            value_r <= {mux_channel, ~mux_channel, 4'h9};
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end

    // data is inverted outside the done pulse so a late sample shows up
    assign conv_done = (left_r == 8'h01);
    assign conv_data = conv_done ? value_r : ~value_r;
endmodule
`default_nettype wire

//--- verif/daq_board_io_register_front_test.sv
// Purpose: self-checking bench for the host register front end
// Assumes: byte strobes driven 1 ns after the rising edge
// Notes:   converter latency is set by the bench through the model
`timescale 1ns/10ps
`default_nettype none
`include "daq_io_regs.svh"
module daq_board_io_register_front_test;
    import daq_io_pkg::*;
    localparam logic [3:0] ID = 4'h6; // value is arbitrary
    logic        ref_clk, rst_b, host_rd, host_wr, conv_start, conv_done;
    logic        irq_gate_bit, dma_transfer_bit, irq_request;
    logic        external_pacer_clock, timer_hold_gate, timer_zero_gate;
    logic        input_config_switch, range_polarity_switch;
    logic [3:0]  host_addr, mux_channel, digital_in_lines, digital_out_lines;
    logic [7:0]  host_wdata, host_rdata, lat, s;
    logic [3:0]  prev_tag;
    logic [11:0] conv_data, dac_a_code, dac_b_code, exp_a, exp_b;
    int          err_count, tests_run;

    daq_board_io_register_front #(.BOARD_ID(ID)) uut (.*);
    conv_engine_model far (.ref_clk(ref_clk), .rst_b(rst_b),
        .conv_start(conv_start), .mux_channel(mux_channel),
        .lat_cycles(lat), .conv_done(conv_done), .conv_data(conv_data));

    // free-running 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle byte strobes; data is valid right after the read edge;
    // an idle edge follows so back to back calls never touch one strobe
    // twice in a time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host_addr  = a;
        host_wdata = d;
        host_wr    = 1'b1;
        @(posedge ref_clk);
        #1;
        host_wr = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        host_addr = a;
        host_rd   = 1'b1;
        @(posedge ref_clk);
        #1;
        s       = host_rdata;
        host_rd = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        rd(a);
        chk({4'h0, s}, {4'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // poll busy with a bound; a hang ends the run as a mismatch
    task automatic wait_idle;
        int n;
        n = 0;
        s = 8'hff;
        while (s[`ST_BUSY_BIT] !== 1'b0 && n < 200) begin
            rd(`OFS_STATUS);
            n++;
        end
        if (s[`ST_BUSY_BIT] !== 1'b0) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, s, 8'h00);
            end_of_test;
        end
    endtask

    // one conversion on channel ch; nx is the counter value expected next
    task automatic convert(input logic [3:0] ch, input logic [3:0] nx,
                           input logic g, input logic d, input logic pv);
        irq_gate_bit     = g;
        dma_transfer_bit = d;
        wr(`OFS_ADC_LOW, 8'hff);
        tick(1);
        rd(`OFS_STATUS);
        chk({11'h0, s[`ST_BUSY_BIT]}, 12'h001);
        chk({8'h0, s[3:0]}, {8'h0, ch});
        chk({8'h0, mux_channel}, {8'h0, ch});
        // status read lands past the 400 ns advance, the high byte read
        // still ahead of the earliest completion
        tick(18);
        rd(`OFS_STATUS);
        chk({8'h0, s[3:0]}, {8'h0, nx});
        if (pv) begin
            rchk(`OFS_ADC_HIGH, {prev_tag, ~prev_tag});
        end
        wait_idle;
        chk({8'h0, s[3:0]}, {8'h0, nx});
        chk({11'h0, s[`ST_IRQ_BIT]}, 12'h001);
        chk({11'h0, irq_request}, {11'h0, g & ~d});
        rchk(`OFS_ADC_LOW, {4'h9, ch});
        rchk(`OFS_ADC_HIGH, {ch, ~ch});
        wr(`OFS_STATUS, 8'h3c);
        tick(1);
        chk({11'h0, irq_request}, 12'h000);
        rd(`OFS_STATUS);
        chk({11'h0, s[`ST_IRQ_BIT]}, 12'h000);
        prev_tag = ch;
    endtask

    // low byte is held; only the high byte moves the code
    task automatic dac(input logic b, input logic [11:0] v);
        wr(b ? `OFS_DAC_B_LOW : `OFS_DAC_A_LOW, {v[3:0], 4'hf});
        tick(1);
        chk(dac_a_code, exp_a);
        chk(dac_b_code, exp_b);
        wr(b ? `OFS_DAC_B_HIGH : `OFS_DAC_A_HIGH, v[11:4]);
        if (b) begin
            exp_b = v;
        end else begin
            exp_a = v;
        end
        tick(1);
        chk(dac_a_code, exp_a);
        chk(dac_b_code, exp_b);
    endtask

    // main sequence: reset, then one test per register group
    initial begin
        {ref_clk, rst_b, host_rd, host_wr, host_addr, host_wdata} = '0;
        {irq_gate_bit, dma_transfer_bit, range_polarity_switch} = '0;
        input_config_switch = 1'b1;
        digital_in_lines    = 4'ha;
        lat       = 8'd30;
        err_count = 0;
        tests_run = 0;
        tick(16);
        rst_b = 1'b1;
        tick(4);
        rchk(`OFS_SCAN, 8'h00);
        rchk(`OFS_DIO, {ID, 4'ha});
        rchk(`OFS_STATUS, 8'h20);
        rchk(4'h4, 8'h00);
        rchk(4'h9, 8'h00);
        chk({8'h0, digital_out_lines}, 12'h000);
        $display("test reset done");
        wr(`OFS_SCAN, 8'h31);
        rchk(`OFS_SCAN, 8'h31);
        rd(`OFS_STATUS);
        chk({8'h0, s[3:0]}, 12'h001);
        convert(4'h1, 4'h2, 1'b1, 1'b0, 1'b0);
        convert(4'h2, 4'h3, 1'b0, 1'b0, 1'b1);
        convert(4'h3, 4'h1, 1'b1, 1'b1, 1'b1);
        lat = 8'd60;
        convert(4'h1, 4'h2, 1'b1, 1'b0, 1'b1);
        wr(`OFS_SCAN, 8'h55);
        rd(`OFS_STATUS);
        chk({8'h0, s[3:0]}, 12'h005);
        convert(4'h5, 4'h5, 1'b1, 1'b0, 1'b1);
        $display("test conversion done");
        wr(`OFS_DIO, 8'ha5);
        chk({8'h0, digital_out_lines}, 12'h005);
        rchk(`OFS_DIO, {ID, 4'ha});
        digital_in_lines = 4'h5;
        tick(4);
        chk({9'h0, external_pacer_clock, timer_hold_gate,
             timer_zero_gate}, 12'h007);
        rchk(`OFS_DIO, {ID, 4'h5});
        digital_in_lines = 4'ha;
        input_config_switch   = 1'b0;
        range_polarity_switch = 1'b1;
        tick(4);
        chk({9'h0, external_pacer_clock, timer_hold_gate,
             timer_zero_gate}, 12'h000);
        rd(`OFS_STATUS);
        chk({10'h0, s[`ST_POL_BIT], s[`ST_CFG_BIT]}, 12'h002);
        $display("test digital done");
        exp_a = 12'h000;
        exp_b = 12'h000;
        dac(1'b0, 12'h9ac);
        dac(1'b1, 12'h36e);
        dac(1'b0, 12'hfff);
        dac(1'b1, 12'h000);
        rchk(`OFS_DAC_A_HIGH, 8'h00);
        $display("test converter codes done");
        end_of_test;
    end
endmodule
`default_nettype wire
